// file: design/ifrp_device.sv
// oscillator end: serial slave, config banks, hold timer and calibration
`timescale 1ns/1ps

// How it works
// [R1] host sets hold before touching config
// [R2] host writes six config bytes while held
// [R3] host releases hold then applies within 10ms
// [R4] late apply after release restores defaults
// [R5] config writes need hold; apply starts calibration
// [R6] 7ppm grade uses bytes 13-18, else 7-12
// [R7] host derives crystal from device's own registers
// [R8] two wires, data bidirectional, clock into device
// [R9] fast mode up to 400 kbps
// [R10] byte data, most significant bit first
// [R11] reads and writes take one or more bytes
// [R12] host ends read with not-acknowledge then stop
// [R13] write: address, pointer, acknowledged data, stop
// [R14] read: pointer, repeated start, address, data
// [R15] slave address fixed, not programmable
// [R16] multiplier 38 bits, 28 fraction bits
// [R17] high-speed divider code maps to 4..11
// [R18] output divider holds ratio minus one, even
// [R19] byte pointer advances after each byte
// [R20] answer own address only, else wait start
module ifrp_device
  import ifrp_pkg::*;
#(
  parameter logic [6:0]  SLAVE_ADDR  = DEF_SLAVE_ADDR,
  parameter int unsigned TIMEOUT_CYC = HOLD_TIMEOUT_CYC,
  parameter int unsigned CALIB_CYC   = CAL_CYC
)(
  input  wire logic               clk,              // 100 MHz clock
  input  wire logic               srst,             // sync reset, high
  ifrp_link_if.device             link,             // serial link
  input  wire logic               stability7ppm,    // grade strap
  output logic [MULT_W-1:0]       freqMultiplier,   // active multiplier
  output logic [3:0]              highSpeedDivider, // active hs ratio
  output logic [7:0]              outputDivider,    // active out ratio
  output logic                    oscillatorHeld,   // hold bit state
  output logic                    calibrating       // restart running
);
  typedef enum logic [2:0] {
    D_IDLE   = 3'b000,
    D_ADDR   = 3'b001,
    D_PTR    = 3'b010,
    D_WDATA  = 3'b011,
    D_ACK    = 3'b100,
    D_RDATA  = 3'b101,
    D_RACK   = 3'b110,
    D_IGNORE = 3'b111
  } ifrp_dev_st_type;

  typedef struct packed {
    ifrp_dev_st_type   st;
    ifrp_dev_st_type   nextSt;
    logic              sclPrev;
    logic              sdaPrev;
    logic [7:0]        shift;
    logic [3:0]        bitCnt;
    logic [7:0]        ptr;
    logic              hostAck;
    logic              sdaOut;
    logic              sdaOeN;
    logic [0:11][7:0]  cfg;
    logic [7:0]        ctrl;
    logic              hold;
    logic              timerOn;
    logic [23:0]       timer;
    logic              calOn;
    logic [23:0]       calCnt;
    logic [MULT_W-1:0] mult;
    logic [3:0]        hsRatio;
    logic [7:0]        outRatio;
  } ifrp_dev_state_type;

  localparam logic [23:0] TO_LAST  = 24'(TIMEOUT_CYC - 1);
  localparam logic [23:0] CAL_LAST = 24'(CALIB_CYC - 1);

  ifrp_dev_state_type q;
  ifrp_dev_state_type d;
  logic               sclRise;
  logic               sclFall;
  logic               startSeen;
  logic               stopSeen;
  logic               loadRd;
  logic [7:0]         rdVal;
  logic [47:0]        bankWord;

  // [R17] divider code decode
  function automatic logic [3:0] hs_ratio(input logic [2:0] code);
    case (code)
      3'h0:    hs_ratio = 4'h4;
      3'h1:    hs_ratio = 4'h5;
      3'h2:    hs_ratio = 4'h6;
      3'h3:    hs_ratio = 4'h7;
      3'h5:    hs_ratio = 4'h9;
      3'h7:    hs_ratio = 4'hB;
      default: hs_ratio = 4'h0;
    endcase
  endfunction

  // [R18] ratio minus one, odd ratios above 1 rounded up
  function automatic logic [7:0] out_ratio(input logic [6:0] code);
    logic [7:0] n;
    n = {1'b0, code} + 8'h01;
    if (n != 8'h01 && n[0])
    begin
      n = n + 8'h01;
    end
    out_ratio = n;
  endfunction

  // [R16] load active settings from a bank word
  function automatic ifrp_dev_state_type load_active(
    input ifrp_dev_state_type s, input logic [47:0] w);
    load_active = s;
    load_active.mult = w[MULT_W-1:0];
    load_active.outRatio = out_ratio(w[OUTDIV_MSB:OUTDIV_LSB]);
    // unused hs codes leave the running divider untouched
    if (hs_ratio(w[HSDIV_MSB:HSDIV_LSB]) != 4'h0)
    begin
      load_active.hsRatio = hs_ratio(w[HSDIV_MSB:HSDIV_LSB]);
    end
  endfunction

  function automatic ifrp_dev_state_type defaults(
    input ifrp_dev_state_type s);
    defaults = load_active(s, CFG_RESET);
    defaults.cfg = {CFG_RESET, CFG_RESET};
  endfunction

  function automatic ifrp_dev_state_type reset_state();
    ifrp_dev_state_type s;
    s = '0;
    s.st = D_IDLE;
    s.nextSt = D_IDLE;
    s.sclPrev = 1'b1;
    s.sdaPrev = 1'b1;
    s.sdaOeN = 1'b1;
    s.ctrl = CTRL_RESET;
    s.hsRatio = 4'h4;
    reset_state = defaults(s);
  endfunction

  // register read view; unmapped addresses read zero
  function automatic logic [7:0] read_reg(
    input ifrp_dev_state_type s, input logic [7:0] a);
    read_reg = 8'h00;
    if (a >= REG_CFG_BASE && a <= REG_CFG_LAST)
    begin
      read_reg = s.cfg[4'(a - REG_CFG_BASE)];
    end
    else if (a == REG_CTRL)
    begin
      read_reg = s.ctrl;
    end
    else if (a == REG_HOLD)
    begin
      read_reg[HOLD_BIT] = s.hold;
    end
  endfunction

  // [R8] [R9] wires sampled at 100 MHz, far above 400 kbps
  assign sclRise   = !q.sclPrev && link.scl;
  assign sclFall   = q.sclPrev && !link.scl;
  assign startSeen = q.sclPrev && link.scl && q.sdaPrev && !link.sda;
  assign stopSeen  = q.sclPrev && link.scl && !q.sdaPrev && link.sda;
  // [R6] grade picks the bank the restart uses
  assign bankWord  = stability7ppm ? q.cfg[6:11] : q.cfg[0:5];

  // next state: timers first so that bus writes in the same cycle win
  always_comb
  begin
    d = q;
    loadRd = 1'b0;
    rdVal = 8'h00;
    d.sclPrev = link.scl;
    d.sdaPrev = link.sda;
    // [R4] release-to-apply deadline
    if (q.timerOn)
    begin
      if (q.timer == TO_LAST)
      begin
        d = defaults(d);
        d.timerOn = 1'b0;
      end
      else
      begin
        d.timer = q.timer + 24'h000001;
      end
    end
    // [R5] calibration restarts with new settings
    if (q.calOn)
    begin
      if (q.calCnt == CAL_LAST)
      begin
        d = load_active(d, bankWord);
        d.calOn = 1'b0;
        d.ctrl[APPLY_BIT] = 1'b0;
      end
      else
      begin
        d.calCnt = q.calCnt + 24'h000001;
      end
    end
    if (startSeen)
    begin
      d.st = D_ADDR;
      d.bitCnt = 4'h0;
      d.sdaOeN = 1'b1;
    end
    else if (stopSeen)
    begin
      d.st = D_IDLE;
      d.sdaOeN = 1'b1;
    end
    else
    begin
      case (q.st)
        D_ADDR, D_PTR, D_WDATA:
        begin
          if (sclRise)
          begin
            // [R10] msb arrives first
            d.shift = {q.shift[6:0], link.sda};
            d.bitCnt = q.bitCnt + 4'h1;
          end
          else if (sclFall && q.bitCnt == 4'h8)
          begin
            d.st = D_ACK;
            d.sdaOeN = 1'b0;
            d.bitCnt = 4'h0;
            if (q.st == D_ADDR)
            begin
              // [R15] [R20] fixed address, others ignored
              if (q.shift[7:1] != SLAVE_ADDR)
              begin
                d.st = D_IGNORE;
                d.sdaOeN = 1'b1;
              end
              // [R13] [R14] direction bit picks path
              d.nextSt = q.shift[0] ? D_RDATA : D_PTR;
            end
            else if (q.st == D_PTR)
            begin
              d.ptr = q.shift;
              d.nextSt = D_WDATA;
            end
            else
            begin
              // [R11] [R19] burst write, pointer advances
              d.ptr = q.ptr + 8'h01;
              d.nextSt = D_WDATA;
              // [R5] config bytes change only while held
              if (q.ptr >= REG_CFG_BASE && q.ptr <= REG_CFG_LAST && q.hold)
              begin
                d.cfg[4'(q.ptr - REG_CFG_BASE)] = q.shift;
              end
              else if (q.ptr == REG_CTRL)
              begin
                d.ctrl = q.shift;
                d.ctrl[APPLY_BIT] = q.ctrl[APPLY_BIT];
                // [R5] apply while running starts calibration
                if (q.shift[APPLY_BIT] && !q.hold)
                begin
                  d.ctrl[APPLY_BIT] = 1'b1;
                  d.calOn = 1'b1;
                  d.calCnt = 24'h000000;
                  d.timerOn = 1'b0;
                end
              end
              else if (q.ptr == REG_HOLD)
              begin
                d.hold = q.shift[HOLD_BIT];
                // [R4] release arms the deadline, re-hold drops it
                d.timerOn = q.hold && !q.shift[HOLD_BIT];
                d.timer = 24'h000000;
              end
            end
          end
        end
        D_ACK:
        begin
          if (sclFall)
          begin
            d.sdaOeN = 1'b1;
            d.st = q.nextSt;
            loadRd = (q.nextSt == D_RDATA);
          end
        end
        D_RDATA:
        begin
          if (sclFall)
          begin
            if (q.bitCnt == 4'h8)
            begin
              d.sdaOeN = 1'b1;
              d.st = D_RACK;
            end
            else
            begin
              d.sdaOeN = q.shift[7];
              d.shift = {q.shift[6:0], 1'b0};
              d.bitCnt = q.bitCnt + 4'h1;
            end
          end
        end
        D_RACK:
        begin
          if (sclRise)
          begin
            d.hostAck = !link.sda;
          end
          else if (sclFall)
          begin
            // [R11] host ack asks for one more byte
            loadRd = q.hostAck;
            d.st = D_IGNORE;
          end
        end
        D_IDLE, D_IGNORE:
        begin
          d.sdaOeN = 1'b1;
        end
        default:
        begin
          d.st = D_IDLE;
        end
      endcase
    end
    // [R19] each read byte advances the pointer
    if (loadRd)
    begin
      rdVal = read_reg(q, q.ptr);
      d.sdaOeN = rdVal[7];
      d.shift = {rdVal[6:0], 1'b0};
      d.ptr = q.ptr + 8'h01;
      d.bitCnt = 4'h1;
      d.st = D_RDATA;
    end
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      q <= reset_state();
    end
    else
    begin
      q <= d;
    end
  end

  assign link.devSdaOut   = q.sdaOut;
  assign link.devSdaOeN   = q.sdaOeN;
  assign freqMultiplier   = q.mult;
  assign highSpeedDivider = q.hsRatio;
  assign outputDivider    = q.outRatio;
  assign oscillatorHeld   = q.hold;
  assign calibrating      = q.calOn;
endmodule

// file: design/ifrp_pkg.sv
// shared constants and types for the oscillator control port
package ifrp_pkg;
  // timing
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned SCL_RATE_KBPS    = 400;
  localparam int unsigned SCL_PERIOD_NS    = 1_000_000 / SCL_RATE_KBPS;
  localparam int unsigned QUARTER_CYC      =
    (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  localparam int unsigned HOLD_TIMEOUT_NS  = 10_000_000;
  localparam int unsigned HOLD_TIMEOUT_CYC = HOLD_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int unsigned CAL_TIME_NS      = 10_000_000;
  localparam int unsigned CAL_CYC          = CAL_TIME_NS / CLK_PERIOD_NS;
  // register offsets
  localparam logic [7:0]  REG_CFG_BASE     = 8'h07;
  localparam logic [7:0]  REG_CFG7_BASE    = 8'h0D;
  localparam logic [7:0]  REG_CFG_LAST     = 8'h12;
  localparam logic [7:0]  REG_CTRL         = 8'h87;
  localparam logic [7:0]  REG_HOLD         = 8'h89;
  localparam int unsigned CFG_BYTES        = 6;
  // field positions
  localparam int unsigned APPLY_BIT        = 6;
  localparam int unsigned HOLD_BIT         = 4;
  localparam int unsigned HSDIV_MSB        = 47;
  localparam int unsigned HSDIV_LSB        = 45;
  localparam int unsigned OUTDIV_MSB       = 44;
  localparam int unsigned OUTDIV_LSB       = 38;
  localparam int unsigned MULT_W           = 38;
  localparam int unsigned MULT_FRAC_W      = 28;
  // reset values and command bytes
  localparam logic [47:0] CFG_RESET        = 48'h01C2BC011EB8;
  localparam logic [7:0]  CTRL_RESET       = 8'h00;
  localparam logic [7:0]  HOLD_SET_VAL     = 8'h10;
  localparam logic [7:0]  HOLD_CLR_VAL     = 8'h00;
  localparam logic [7:0]  APPLY_VAL        = 8'h40;
  localparam logic [6:0]  DEF_SLAVE_ADDR   = 7'h55;

  typedef enum logic [1:0] {
    CMD_WRITE   = 2'b00,
    CMD_READ    = 2'b01,
    CMD_PROGRAM = 2'b10
  } ifrp_cmd_type;

  typedef struct packed {
    logic [7:0]  regAddr;
    logic [2:0]  len;
    logic [47:0] data;
  } ifrp_txn_type;
endpackage

// file: design/ifrp_link_if.sv
// two-wire control link joining host and oscillator ends
`timescale 1ns/1ps
interface ifrp_link_if;
  logic hostSclOut;
  logic hostSclOeN;
  logic hostSdaOut;
  logic hostSdaOeN;
  logic devSdaOut;
  logic devSdaOeN;
  logic scl;
  logic sda;

  // external pull-ups: a wire is high unless some end enables its driver
  assign scl = hostSclOeN ? 1'b1 : hostSclOut;
  assign sda = (hostSdaOeN ? 1'b1 : hostSdaOut)
             & (devSdaOeN ? 1'b1 : devSdaOut);

  modport device (input scl, sda, output devSdaOut, devSdaOeN);
  modport host   (input scl, sda,
                  output hostSclOut, hostSclOeN, hostSdaOut, hostSdaOeN);
endinterface

// file: design/ifrp_host.sv
// host end: bus master with single, burst and reprogram commands
`timescale 1ns/1ps
module ifrp_host
  import ifrp_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = DEF_SLAVE_ADDR
)(
  input  wire logic          clk,        // 100 MHz clock
  input  wire logic          srst,       // sync reset, high
  ifrp_link_if.host          link,       // serial link
  input  wire logic          cmdValid,   // command offered
  input  wire ifrp_cmd_type  cmdKind,    // write, read or program
  input  wire logic [7:0]    cmdRegAddr, // first register
  input  wire logic [2:0]    cmdLen,     // bytes, 1..6
  input  wire logic [47:0]   cmdData,    // write bytes, msb first
  input  wire logic          cmdBank7,   // device is 7 ppm grade
  output logic               cmdReady,   // idle, command taken
  output logic               rspDone,    // one-cycle completion
  output logic               rspNack,    // device refused a byte
  output logic [47:0]        rspData     // read bytes, last in low
);
  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_START = 2'b01,
    H_BIT   = 2'b10,
    H_STOP  = 2'b11
  } ifrp_host_st_type;

  typedef struct packed {
    ifrp_host_st_type st;
    logic [1:0]       ph;
    logic [5:0]       qc;
    logic [3:0]       bitCnt;
    logic [7:0]       tx;
    logic [7:0]       rx;
    logic             rxMode;
    logic             readPhase;
    logic             ackSeen;
    logic [1:0]       seq;
    logic [2:0]       byteIdx;
    logic [2:0]       rcvCnt;
    ifrp_cmd_type     kind;
    logic [7:0]       cAddr;
    logic [2:0]       cLen;
    logic [47:0]      cData;
    logic             cBank7;
    ifrp_txn_type     txn;
    logic [47:0]      rd;
    logic             sclOeN;
    logic             sdaOeN;
    logic             ready;
    logic             done;
    logic             nack;
  } ifrp_host_state_type;

  localparam logic [5:0] QC_LAST = 6'(QUARTER_CYC - 1);

  ifrp_host_state_type q;
  ifrp_host_state_type d;
  logic                tick;
  logic                lastRx;

  // one bus transaction of a command
  function automatic ifrp_txn_type plan(
    input ifrp_cmd_type k, input logic [1:0] s, input logic [7:0] a,
    input logic [2:0] n, input logic [47:0] w, input logic b7);
    plan.regAddr = a;
    plan.len = (n == 3'h0) ? 3'h1 : (n > 3'h6 ? 3'h6 : n);
    plan.data = w;
    if (k == CMD_PROGRAM)
    begin
      case (s)
        // [R1] hold before config changes
        2'h0:    plan = '{REG_HOLD, 3'h1, {HOLD_SET_VAL, 40'h0}};
        // [R2] [R6] six bytes into the grade's bank
        2'h1:    plan = '{b7 ? REG_CFG7_BASE : REG_CFG_BASE, 3'h6, w};
        // [R3] release, apply right behind it
        2'h2:    plan = '{REG_HOLD, 3'h1, {HOLD_CLR_VAL, 40'h0}};
        default: plan = '{REG_CTRL, 3'h1, {APPLY_VAL, 40'h0}};
      endcase
    end
  endfunction

  // [R9] quarter-period ticks keep scl at or below 400 kHz
  assign tick   = (q.qc == QC_LAST);
  assign lastRx = (q.rcvCnt == 3'(q.txn.len - 3'h1));

  always_comb
  begin
    d = q;
    d.done = 1'b0;
    if (q.st != H_IDLE)
    begin
      d.qc = tick ? 6'h00 : q.qc + 6'h01;
    end
    case (q.st)
      H_IDLE:
      begin
        d.ready = 1'b1;
        if (cmdValid && q.ready)
        begin
          d = '{st: H_START, kind: cmdKind, cAddr: cmdRegAddr,
                cLen: cmdLen, cData: cmdData, cBank7: cmdBank7,
                txn: plan(cmdKind, 2'h0, cmdRegAddr, cmdLen, cmdData,
                          cmdBank7),
                sclOeN: 1'b1, sdaOeN: 1'b1, default: '0};
        end
      end
      H_START:
      begin
        // [R14] same edge order serves start and repeated start
        if (tick)
        begin
          d.ph = q.ph + 2'h1;
          case (q.ph)
            2'h0:    d.sdaOeN = 1'b1;
            2'h1:    d.sclOeN = 1'b1;
            2'h2:    d.sdaOeN = 1'b0;
            default:
            begin
              d.sclOeN = 1'b0;
              d.st = H_BIT;
              d.bitCnt = 4'h0;
              d.rxMode = 1'b0;
              d.tx = {SLAVE_ADDR, q.readPhase};
            end
          endcase
        end
      end
      H_BIT:
      begin
        if (tick)
        begin
          d.ph = q.ph + 2'h1;
          case (q.ph)
            2'h0:
            begin
              // [R10] [R12] msb first; ack all read bytes but last
              if (q.bitCnt != 4'h8)
              begin
                d.sdaOeN = q.rxMode ? 1'b1 : q.tx[7];
              end
              else
              begin
                d.sdaOeN = q.rxMode ? lastRx : 1'b1;
              end
            end
            2'h1:    d.sclOeN = 1'b1;
            2'h2:
            begin
              if (q.bitCnt != 4'h8)
              begin
                d.rx = {q.rx[6:0], link.sda};
                d.tx = {q.tx[6:0], 1'b0};
              end
              else
              begin
                d.ackSeen = !link.sda;
              end
            end
            default:
            begin
              d.sclOeN = 1'b0;
              d.bitCnt = q.bitCnt + 4'h1;
              if (q.bitCnt == 4'h8)
              begin
                d.bitCnt = 4'h0;
                if (q.rxMode)
                begin
                  // [R7] raw register bytes returned for crystal maths
                  d.rd = {q.rd[39:0], q.rx};
                  d.rcvCnt = q.rcvCnt + 3'h1;
                  // [R12] not-acknowledge then stop
                  if (lastRx)
                  begin
                    d.st = H_STOP;
                  end
                end
                else if (!q.ackSeen)
                begin
                  d.nack = 1'b1;
                  d.st = H_STOP;
                end
                else if (q.readPhase)
                begin
                  d.rxMode = 1'b1;
                  d.rcvCnt = 3'h0;
                end
                // [R14] pointer sent, turn round with repeated start
                else if (q.kind == CMD_READ && q.byteIdx == 3'h1)
                begin
                  d.st = H_START;
                  d.readPhase = 1'b1;
                end
                // [R13] stop after the last data byte
                else if (q.byteIdx == q.txn.len + 3'h1)
                begin
                  d.st = H_STOP;
                end
                else
                begin
                  d.byteIdx = q.byteIdx + 3'h1;
                  d.tx = q.txn.data[47:40];
                  d.txn.data = {q.txn.data[39:0], 8'h00};
                  if (q.byteIdx == 3'h0)
                  begin
                    d.tx = q.txn.regAddr;
                    d.txn.data = q.txn.data;
                  end
                end
              end
            end
          endcase
        end
      end
      H_STOP:
      begin
        if (tick)
        begin
          d.ph = q.ph + 2'h1;
          case (q.ph)
            2'h0:    d.sdaOeN = 1'b0;
            2'h1:    d.sclOeN = 1'b1;
            2'h2:    d.sdaOeN = 1'b1;
            default:
            begin
              // [R3] next program step follows at once
              if (q.kind == CMD_PROGRAM && q.seq != 2'h3 && !q.nack)
              begin
                d.seq = q.seq + 2'h1;
                d.txn = plan(q.kind, q.seq + 2'h1, q.cAddr, q.cLen,
                             q.cData, q.cBank7);
                d.byteIdx = 3'h0;
                d.readPhase = 1'b0;
                d.st = H_START;
              end
              else
              begin
                d.st = H_IDLE;
                d.done = 1'b1;
              end
            end
          endcase
        end
      end
      default: d.st = H_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      q <= '{st: H_IDLE, kind: CMD_WRITE, sclOeN: 1'b1, sdaOeN: 1'b1,
             default: '0};
    end
    else
    begin
      q <= d;
    end
  end

  // [R8] open-drain: pins only ever pull low
  assign link.hostSclOut = 1'b0;
  assign link.hostSdaOut = 1'b0;
  assign link.hostSclOeN = q.sclOeN;
  assign link.hostSdaOeN = q.sdaOeN;
  assign cmdReady        = q.ready;
  assign rspDone         = q.done;
  assign rspNack         = q.nack;
  assign rspData         = q.rd;
endmodule

// file: test/ifrp_link_asserts.sv
// wire-level checks on the two-wire link between host and device
`timescale 1ns/1ps
module ifrp_link_asserts (
  input wire logic clk,        // system clock
  input wire logic srst,       // sync reset
  input wire logic scl,        // resolved clock wire
  input wire logic hostSclOut, // host clock level
  input wire logic hostSclOeN, // host clock enable
  input wire logic hostSdaOut, // host data level
  input wire logic devSdaOut,  // device data level
  input wire logic devSdaOeN   // device data enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // both ends come out of reset with wires released
  a_reset_releases: assert property ($fell(srst) |-> hostSclOeN && devSdaOeN)
    else $error("link not released after reset");
  // open drain only: a driven wire is always pulled low
  a_open_drain_low: assert property (!hostSclOut && !hostSdaOut && !devSdaOut)
    else $error("an end drove a wire high");
  // device data may only move while the clock is low
  a_dev_ack_low: assert property ($fell(devSdaOeN) |-> !scl)
    else $error("device pulled data with clock high");
  a_dev_release_low: assert property ($rose(devSdaOeN) |-> !scl)
    else $error("device released data with clock high");
  a_dev_data_stable: assert property (scl && $past(scl) |-> $stable(devSdaOeN))
    else $error("device data moved during clock high");
  // fast mode limit: no clock phase shorter than a few cycles
  a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  a_scl_low_min: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase too short");
  // two quarters of 63 cycles per low phase, never stuck low
  a_scl_low_bound: assert property ($fell(scl) |-> ##[100:200] scl)
    else $error("clock low phase out of range");
endmodule

// file: test/i2c_frequency_reprogram_port_test.sv
// self-checking bench joining the host and oscillator ends
`timescale 1ns/1ps
module i2c_frequency_reprogram_port_test
  import ifrp_pkg::*;
;
  typedef struct packed {
    ifrp_cmd_type kind;
    logic [7:0]   addr;
    logic [2:0]   len;
    logic [47:0]  data;
    logic [47:0]  rsp;
  } ifrp_row_type;
  localparam logic [47:0] NEW_CFG = 48'h01C2D1E12788;
  logic              clk;
  logic              srst;
  logic              cmdValid;
  ifrp_cmd_type      cmdKind;
  logic [7:0]        cmdRegAddr;
  logic [2:0]        cmdLen;
  logic [47:0]       cmdData;
  logic              cmdReady;
  logic              rspDone;
  logic              rspNack;
  logic [47:0]       rspData;
  logic [MULT_W-1:0] freqMultiplier;
  logic [3:0]        highSpeedDivider;
  logic [7:0]        outputDivider;
  logic              oscillatorHeld;
  logic              calibrating;
  int                mismatches = 0;
  int                checks = 0;
  ifrp_row_type      rows [2] = '{
    '{CMD_PROGRAM, 8'h07, 3'h6, NEW_CFG, 48'h0},
    '{CMD_READ, 8'h07, 3'h6, 48'h0, NEW_CFG}};

  ifrp_link_if ifrp_link_if_inst ();
  ifrp_host ifrp_host_inst (.clk(clk), .srst(srst), .link(ifrp_link_if_inst),
    .cmdValid(cmdValid), .cmdKind(cmdKind), .cmdRegAddr(cmdRegAddr),
    .cmdLen(cmdLen), .cmdData(cmdData), .cmdBank7(1'b0),
    .cmdReady(cmdReady), .rspDone(rspDone), .rspNack(rspNack),
    .rspData(rspData));
  // timeout must outlast the release-to-apply gap of about 7300 cycles
  ifrp_device #(.TIMEOUT_CYC(10000), .CALIB_CYC(20)) ifrp_device_inst (
    .clk(clk), .srst(srst), .link(ifrp_link_if_inst), .stability7ppm(1'b0),
    .freqMultiplier(freqMultiplier), .highSpeedDivider(highSpeedDivider),
    .outputDivider(outputDivider), .oscillatorHeld(oscillatorHeld),
    .calibrating(calibrating));
  ifrp_link_asserts ifrp_link_asserts_inst (.clk(clk), .srst(srst),
    .scl(ifrp_link_if_inst.scl), .hostSclOut(ifrp_link_if_inst.hostSclOut),
    .hostSclOeN(ifrp_link_if_inst.hostSclOeN),
    .hostSdaOut(ifrp_link_if_inst.hostSdaOut),
    .devSdaOut(ifrp_link_if_inst.devSdaOut),
    .devSdaOeN(ifrp_link_if_inst.devSdaOeN));

  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic test_done;
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(string name, logic [47:0] exp, logic [47:0] got);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // offer one command, then wait for its completion pulse
  task automatic run(ifrp_row_type r);
    int n;
    cmdKind = r.kind;
    cmdRegAddr = r.addr;
    cmdLen = r.len;
    cmdData = r.data;
    cmdValid = 1'b1;
    for (n = 0; n < 100 && cmdReady !== 1'b1; n++)
      @(posedge clk) #1;
    if (n >= 100)
      mismatches++;
    @(posedge clk) #1;
    cmdValid = 1'b0;
    // a program command spans four bus transactions
    for (n = 0; n < 60000 && rspDone !== 1'b1; n++)
      @(posedge clk) #1;
    if (n >= 60000)
    begin
      mismatches++;
      test_done;
    end
  endtask

  // main sequence
  initial
  begin
    srst = 1'b1;
    cmdValid = 1'b0;
    cmdKind = CMD_WRITE;
    cmdRegAddr = 8'h00;
    cmdLen = 3'h0;
    cmdData = 48'h0;
    repeat (20) @(posedge clk);
    #1;
    check("cmdReady", 48'h0, 48'(cmdReady));
    check("freqMultiplier", 48'h2BC011EB8, 48'(freqMultiplier));
    srst = 1'b0;
    foreach (rows[i])
    begin
      run(rows[i]);
      check("rspNack", 48'h0, 48'(rspNack));
      if (rows[i].kind == CMD_READ)
        check("rspData", rows[i].rsp, rspData);
    end
    check("freqMultiplier", 48'h2D1E12788, 48'(freqMultiplier));
    check("highSpeedDivider", 48'h4, 48'(highSpeedDivider));
    check("outputDivider", 48'h8, 48'(outputDivider));
    check("calibrating", 48'h0, 48'(calibrating));
    // hold, release and never apply: defaults must come back
    run('{CMD_WRITE, REG_HOLD, 3'h1, {HOLD_SET_VAL, 40'h0}, 48'h0});
    check("oscillatorHeld", 48'h1, 48'(oscillatorHeld));
    run('{CMD_WRITE, REG_HOLD, 3'h1, {HOLD_CLR_VAL, 40'h0}, 48'h0});
    check("oscillatorHeld", 48'h0, 48'(oscillatorHeld));
    check("freqMultiplier", 48'h2D1E12788, 48'(freqMultiplier));
    repeat (10000) @(posedge clk);
    check("freqMultiplier", 48'h2BC011EB8, 48'(freqMultiplier));
    test_done;
  end
endmodule
